// File: rtl/scg_defines.vh
`ifndef SCG_DEFINES_VH
`define SCG_DEFINES_VH
// register byte offsets
`define SCG_OFS_SEL 8'h00
`define SCG_OFS_MON 8'h04
`define SCG_OFS_FREQ 8'h08
`define SCG_OFS_DIV 8'h0c
`define SCG_OFS_TMR_RC 8'h10
`define SCG_OFS_TMR_MAIN 8'h14
`define SCG_OFS_TMR_SUB 8'h18
// select / monitor register fields
`define SCG_SEL1_LSB 0
`define SCG_SEL2_LSB 4
`define SCG_RCE_BIT 8
`define SCG_MCE_BIT 9
`define SCG_PCE_BIT 10
`define SCG_SCE_BIT 11
`define SCG_SEL_WMASK 32'h00000f33
`define SCG_SEL_RESET 32'h00000b00
// frequency control fields
`define SCG_RC_FREQ_SELECT_BIT 0
`define SCG_MUL_LSB 8
`define SCG_FREQ_WMASK 32'h00000f01
`define SCG_FREQ_RESET 32'h00000100
`define SCG_MUL_MIN 4'h1
`define SCG_MUL_MAX 4'hd
// divider fields, ratio is field plus one
`define SCG_BDIV_LSB 0
`define SCG_P1DIV_LSB 8
`define SCG_P2DIV_LSB 16
`define SCG_DIV_WMASK 32'h000f0f0f
`define SCG_DIV_RESET 32'h00000000
// source codes
`define SCG_SRC_RC 2'h0
`define SCG_SRC_MAIN 2'h1
`define SCG_SRC_PLL 2'h2
`define SCG_SRC_SUB 2'h3
// power modes
`define SCG_MODE_RUN 2'h0
`define SCG_MODE_SLEEP 2'h1
`define SCG_MODE_TIMER 2'h2
`define SCG_MODE_STOP 2'h3
// axi responses
`define SCG_RESP_OKAY 2'h0
`define SCG_RESP_SLVERR 2'h2
// timing
`define SCG_CLK_KHZ 25000
`define SCG_CLK_PERIOD_NS 40
`define SCG_RC_FAST_KHZ 2000
`define SCG_RC_SLOW_KHZ 100
`define SCG_RC_STAB_NS 10000
`define SCG_PLL_LOCK_NS 20000
`define SCG_RC_STAB_CYC ((`SCG_RC_STAB_NS+`SCG_CLK_PERIOD_NS-1)/`SCG_CLK_PERIOD_NS)
`define SCG_PLL_LOCK_CYC ((`SCG_PLL_LOCK_NS+`SCG_CLK_PERIOD_NS-1)/`SCG_CLK_PERIOD_NS)
`endif

// File: rtl/scg_tick_gen.v
`timescale 1ns/1ns
// fractional tick generator: inc ticks per modv advances
module scg_tick_gen #(
  parameter ACC_W = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire en,
  input wire adv,
  input wire [ACC_W-1:0] inc,
  input wire [ACC_W-1:0] modv,
  output reg tick
);
  reg [ACC_W-1:0] acc_reg;
  wire [ACC_W:0] sum;
  wire [ACC_W:0] diff;

  assign sum = {1'b0, acc_reg} + {1'b0, inc};
  assign diff = sum - {1'b0, modv};

  // phase restarts at zero on enable, so the first period is whole
  always @(posedge aclk) begin
    if (!aresetn || !en) begin
      acc_reg <= {ACC_W{1'b0}};
      tick <= 1'b0;
    end else if (adv) begin
      if (sum >= {1'b0, modv}) begin
        acc_reg <= diff[ACC_W-1:0];
        tick <= 1'b1;
      end else begin
        acc_reg <= sum[ACC_W-1:0];
        tick <= 1'b0;
      end
    end else begin
      tick <= 1'b0;
    end
  end
endmodule // scg_tick_gen

// File: rtl/scg_clock_gen.v
// Functional notes
// - four sources: rc, main, multiplied, sub
// - rc runs 2MHz or 100kHz by select
// - multiplied clock is main times 1..13
// - multiplied clock only while main active
// - two-bit field picks system clock one
// - system one feeds bus, periph one, mode
// - bus clock divided from system clock one
// - bus clock stops in all standby modes
// - periph one has its own divider
// - periph clocks stop in timer, stop
// - separate field picks system clock two
// - system two feeds only periph two divider
// - periph two has dedicated divider
// - system two choice leaves cpu mode alone
// - rc, main, sub timers always run; code stops each while its source is disabled, sub also when pins freed
// - sub marker unused frees sub pins
// - reset selects rc for both systems
// - switch waits until new source ready
// - monitor updates after switch completes
// - newer select value replaces pending one
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
`include "scg_defines.vh"
module scg_clock_gen #(
  parameter MAIN_KHZ = 1000,
  parameter SUB_KHZ = 32,
  parameter ACC_W = 16,
  parameter DIV_W = 4,
  parameter TMR_W = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire main_osc_stable,
  input wire sub_osc_stable,
  input wire sub_osc_config_marker,
  input wire [1:0] standby_mode,
  output reg bus_clock_en,
  output reg peripheral_clock_one_en,
  output reg peripheral_clock_two_en,
  output reg [1:0] cpu_clock_mode,
  output reg sub_pins_gpio
);
  // multiplied clock must stay below the system clock rate
  localparam [ACC_W-1:0] CLK_MOD = `SCG_CLK_KHZ;
  localparam [ACC_W-1:0] RC_FAST = `SCG_RC_FAST_KHZ;
  localparam [ACC_W-1:0] RC_SLOW = `SCG_RC_SLOW_KHZ;
  localparam [ACC_W-1:0] MAIN_INC = MAIN_KHZ[ACC_W-1:0];
  localparam [ACC_W-1:0] SUB_INC = SUB_KHZ[ACC_W-1:0];
  localparam [ACC_W-1:0] ONE = 1;
  localparam integer RC_STAB_INT = `SCG_RC_STAB_CYC;
  localparam integer PLL_LOCK_INT = `SCG_PLL_LOCK_CYC;
  localparam [15:0] RC_STAB_CYC = RC_STAB_INT[15:0];
  localparam [15:0] PLL_LOCK_CYC = PLL_LOCK_INT[15:0];

  reg [31:0] clock_select_reg;
  reg [31:0] clock_freq_control_reg;
  reg [31:0] clock_div_reg;
  reg [1:0] sys1_mon_reg;
  reg [1:0] sys2_mon_reg;
  reg [DIV_W-1:0] bus_ratio_reg;
  reg [DIV_W-1:0] p1_ratio_reg;
  reg [DIV_W-1:0] p2_ratio_reg;
  reg [15:0] rc_stab_reg;
  reg [15:0] pll_lock_reg;
  reg [TMR_W-1:0] rc_timer_reg;
  reg [TMR_W-1:0] main_timer_reg;
  reg [TMR_W-1:0] sub_timer_reg;
  reg marker_taken_reg;
  reg [7:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg [31:0] rd_data;
  reg rd_err;

  wire [1:0] sys1_source_select;
  wire [1:0] sys2_source_select;
  wire rc_freq_select;
  wire [3:0] mul_field;
  wire [3:0] pll_mul;
  wire [3:0] sel_hit;
  wire rc_act;
  wire main_act;
  wire pll_act;
  wire sub_act;
  wire rc_ready;
  wire main_ready;
  wire pll_ready;
  wire sub_ready;
  wire [3:0] src_ready;
  wire [3:0] src_tick;
  wire rc_osc_clock;
  wire main_osc_clock;
  wire multiplied_clock;
  wire sub_osc_clock;
  wire system_clock_one;
  wire system_clock_two;
  wire bus_clock;
  wire peripheral_clock_one;
  wire peripheral_clock_two;
  wire [ACC_W-1:0] rc_inc;
  wire [ACC_W-1:0] pll_inc;
  wire [31:0] clock_monitor_reg;
  wire [31:0] wmask;
  wire aw_hs;
  wire w_hs;
  wire do_write;
  wire ar_hs;

  assign sys1_source_select = clock_select_reg[`SCG_SEL1_LSB+1:`SCG_SEL1_LSB];
  assign sys2_source_select = clock_select_reg[`SCG_SEL2_LSB+1:`SCG_SEL2_LSB];
  assign rc_freq_select = clock_freq_control_reg[`SCG_RC_FREQ_SELECT_BIT];
  assign mul_field = clock_freq_control_reg[`SCG_MUL_LSB+3:`SCG_MUL_LSB];
  // out-of-range factors clamp instead of stalling the source
  assign pll_mul = (mul_field < `SCG_MUL_MIN) ? `SCG_MUL_MIN :
                   (mul_field > `SCG_MUL_MAX) ? `SCG_MUL_MAX :
                   mul_field;

  // sources in use by a selector, current or pending, stay on; sub only while sub_pins_gpio is low
  assign sel_hit = (4'h1 << sys1_source_select) |
                   (4'h1 << sys2_source_select) |
                   (4'h1 << sys1_mon_reg) | (4'h1 << sys2_mon_reg);
  assign rc_act = clock_select_reg[`SCG_RCE_BIT] | sel_hit[0];
  assign main_act = clock_select_reg[`SCG_MCE_BIT] | sel_hit[1] |
                    sel_hit[2];
  assign pll_act = (clock_select_reg[`SCG_PCE_BIT] | sel_hit[2]) &
                   main_act;
  assign sub_act = (clock_select_reg[`SCG_SCE_BIT] | sel_hit[3]) &
                   ~sub_pins_gpio;

  assign rc_ready = rc_act && (rc_stab_reg == RC_STAB_CYC);
  assign main_ready = main_act & main_osc_stable;
  assign pll_ready = pll_act && main_ready &&
                     (pll_lock_reg == PLL_LOCK_CYC);
  assign sub_ready = sub_act & sub_osc_stable;
  assign src_ready = {sub_ready, pll_ready, main_ready, rc_ready};
  assign src_tick = {sub_osc_clock, multiplied_clock, main_osc_clock,
                     rc_osc_clock};

  assign rc_inc = rc_freq_select ? RC_SLOW : RC_FAST;
  assign pll_inc = MAIN_INC * {{(ACC_W-4){1'b0}}, pll_mul};

  scg_tick_gen #(.ACC_W(ACC_W)) u_rc (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(rc_act),
    .adv(1'b1),
    .inc(rc_inc),
    .modv(CLK_MOD),
    .tick(rc_osc_clock)
  );

  scg_tick_gen #(.ACC_W(ACC_W)) u_main (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(main_act),
    .adv(1'b1),
    .inc(MAIN_INC),
    .modv(CLK_MOD),
    .tick(main_osc_clock)
  );

  scg_tick_gen #(.ACC_W(ACC_W)) u_pll (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(pll_act),
    .adv(1'b1),
    .inc(pll_inc),
    .modv(CLK_MOD),
    .tick(multiplied_clock)
  );

  scg_tick_gen #(.ACC_W(ACC_W)) u_sub (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(sub_act),
    .adv(1'b1),
    .inc(SUB_INC),
    .modv(CLK_MOD),
    .tick(sub_osc_clock)
  );

  assign system_clock_one = src_tick[sys1_mon_reg];
  assign system_clock_two = src_tick[sys2_mon_reg];

  scg_tick_gen #(.ACC_W(ACC_W)) u_bus_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(1'b1),
    .adv(system_clock_one),
    .inc(ONE),
    .modv({{(ACC_W-DIV_W){1'b0}}, bus_ratio_reg} + ONE),
    .tick(bus_clock)
  );

  scg_tick_gen #(.ACC_W(ACC_W)) u_p1_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(1'b1),
    .adv(system_clock_one),
    .inc(ONE),
    .modv({{(ACC_W-DIV_W){1'b0}}, p1_ratio_reg} + ONE),
    .tick(peripheral_clock_one)
  );

  scg_tick_gen #(.ACC_W(ACC_W)) u_p2_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(1'b1),
    .adv(system_clock_two),
    .inc(ONE),
    .modv({{(ACC_W-DIV_W){1'b0}}, p2_ratio_reg} + ONE),
    .tick(peripheral_clock_two)
  );

  // switching only on a tick of the new source keeps every period whole
  always @(posedge aclk) begin
    if (!aresetn) begin
      sys1_mon_reg <= `SCG_SRC_RC;
      sys2_mon_reg <= `SCG_SRC_RC;
      cpu_clock_mode <= `SCG_SRC_RC;
    end else begin
      if (sys1_source_select != sys1_mon_reg &&
          src_ready[sys1_source_select] &&
          src_tick[sys1_source_select]) begin
        sys1_mon_reg <= sys1_source_select;
        cpu_clock_mode <= sys1_source_select;
      end
      if (sys2_source_select != sys2_mon_reg &&
          src_ready[sys2_source_select] &&
          src_tick[sys2_source_select]) begin
        sys2_mon_reg <= sys2_source_select;
      end
    end
  end

  // ratios load only at a divider wrap, so no period is cut short
  always @(posedge aclk) begin
    if (!aresetn) begin
      bus_ratio_reg <= {DIV_W{1'b0}};
      p1_ratio_reg <= {DIV_W{1'b0}};
      p2_ratio_reg <= {DIV_W{1'b0}};
    end else begin
      if (bus_clock) begin
        bus_ratio_reg <= clock_div_reg[`SCG_BDIV_LSB+DIV_W-1:`SCG_BDIV_LSB];
      end
      if (peripheral_clock_one) begin
        p1_ratio_reg <= clock_div_reg[`SCG_P1DIV_LSB+DIV_W-1:`SCG_P1DIV_LSB];
      end
      if (peripheral_clock_two) begin
        p2_ratio_reg <= clock_div_reg[`SCG_P2DIV_LSB+DIV_W-1:`SCG_P2DIV_LSB];
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      bus_clock_en <= 1'b0;
      peripheral_clock_one_en <= 1'b0;
      peripheral_clock_two_en <= 1'b0;
    end else begin
      bus_clock_en <= bus_clock &&
                      (standby_mode == `SCG_MODE_RUN);
      peripheral_clock_one_en <= peripheral_clock_one &&
                                 standby_mode != `SCG_MODE_TIMER &&
                                 standby_mode != `SCG_MODE_STOP;
      peripheral_clock_two_en <= peripheral_clock_two &&
                                 standby_mode != `SCG_MODE_TIMER &&
                                 standby_mode != `SCG_MODE_STOP;
    end
  end

  // stabilisation and lock waits restart whenever the source stops
  always @(posedge aclk) begin
    if (!aresetn) begin
      rc_stab_reg <= 16'h0000;
      pll_lock_reg <= 16'h0000;
    end else begin
      if (!rc_act) begin
        rc_stab_reg <= 16'h0000;
      end else if (rc_stab_reg != RC_STAB_CYC) begin
        rc_stab_reg <= rc_stab_reg + 16'h0001;
      end
      if (!pll_act || !main_ready) begin
        pll_lock_reg <= 16'h0000;
      end else if (pll_lock_reg != PLL_LOCK_CYC) begin
        pll_lock_reg <= pll_lock_reg + 16'h0001;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rc_timer_reg <= {TMR_W{1'b0}};
      main_timer_reg <= {TMR_W{1'b0}};
      sub_timer_reg <= {TMR_W{1'b0}};
    end else begin
      if (rc_osc_clock) begin
        rc_timer_reg <= rc_timer_reg + ONE[TMR_W-1:0];
      end
      if (main_osc_clock) begin
        main_timer_reg <= main_timer_reg + ONE[TMR_W-1:0];
      end
      if (sub_osc_clock) begin
        sub_timer_reg <= sub_timer_reg + ONE[TMR_W-1:0];
      end
    end
  end

  // the marker is a strap: caught on the first edge after release
  always @(posedge aclk) begin
    if (!aresetn) begin
      marker_taken_reg <= 1'b0;
      sub_pins_gpio <= 1'b0;
    end else if (!marker_taken_reg) begin
      marker_taken_reg <= 1'b1;
      sub_pins_gpio <= sub_osc_config_marker;
    end
  end

  assign clock_monitor_reg = {20'h00000, sub_ready, pll_ready, main_ready,
                              rc_ready, 2'b00, sys2_mon_reg, 2'b00,
                              sys1_mon_reg};

  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs = s_axi_wvalid & s_axi_wready;
  assign do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign ar_hs = s_axi_arvalid & s_axi_arready;
  assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                  {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SCG_RESP_OKAY;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      clock_select_reg <= `SCG_SEL_RESET;
      clock_freq_control_reg <= `SCG_FREQ_RESET;
      clock_div_reg <= `SCG_DIV_RESET;
    end else begin
      if (aw_hs) begin
        aw_addr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_hs) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `SCG_RESP_OKAY;
        case (aw_addr_reg & 8'hfc)
          `SCG_OFS_SEL: begin
            clock_select_reg <= (clock_select_reg & ~(wmask &
              `SCG_SEL_WMASK)) | (w_data_reg & wmask & `SCG_SEL_WMASK);
          end
          `SCG_OFS_FREQ: begin
            clock_freq_control_reg <= (clock_freq_control_reg & ~(wmask &
              `SCG_FREQ_WMASK)) | (w_data_reg & wmask & `SCG_FREQ_WMASK);
          end
          `SCG_OFS_DIV: begin
            clock_div_reg <= (clock_div_reg & ~(wmask &
              `SCG_DIV_WMASK)) | (w_data_reg & wmask & `SCG_DIV_WMASK);
          end
          `SCG_OFS_MON, `SCG_OFS_TMR_RC, `SCG_OFS_TMR_MAIN,
          `SCG_OFS_TMR_SUB: begin
            s_axi_bresp <= `SCG_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `SCG_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always @* begin
    rd_data = 32'h00000000;
    rd_err = 1'b0;
    case (s_axi_araddr & 8'hfc)
      `SCG_OFS_SEL: rd_data = clock_select_reg;
      `SCG_OFS_MON: rd_data = clock_monitor_reg;
      `SCG_OFS_FREQ: rd_data = clock_freq_control_reg;
      `SCG_OFS_DIV: rd_data = clock_div_reg;
      `SCG_OFS_TMR_RC: rd_data[TMR_W-1:0] = rc_timer_reg;
      `SCG_OFS_TMR_MAIN: rd_data[TMR_W-1:0] = main_timer_reg;
      `SCG_OFS_TMR_SUB: rd_data[TMR_W-1:0] = sub_timer_reg;
      default: rd_err = 1'b1;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SCG_RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_err ? `SCG_RESP_SLVERR : `SCG_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // scg_clock_gen

// File: test/scg_osc_model.sv
`timescale 1ns/1ns
module scg_osc_model #(
  parameter MAIN_WAIT = 100,
  parameter SUB_WAIT = 200
) (
  input wire aclk,
  input wire main_on,
  input wire sub_on,
  output reg main_osc_stable = 1'b0,
  output reg sub_osc_stable = 1'b0
);
  integer main_cnt = 0;
  integer sub_cnt = 0;
  // a stopped oscillator loses stability at once, regains it after the wait
  always @(posedge aclk) begin
    main_cnt <= main_on ? main_cnt + 1 : 0;
    sub_cnt <= sub_on ? sub_cnt + 1 : 0;
    main_osc_stable <= main_on && main_cnt >= MAIN_WAIT;
    sub_osc_stable <= sub_on && sub_cnt >= SUB_WAIT;
  end
endmodule // scg_osc_model

// File: test/scg_clock_gen_assertions.sv
`timescale 1ns/1ns
module scg_clock_gen_checker (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire sub_osc_config_marker,
  input wire [1:0] standby_mode,
  input wire bus_clock_en,
  input wire peripheral_clock_one_en,
  input wire peripheral_clock_two_en,
  input wire [1:0] cpu_clock_mode,
  input wire sub_pins_gpio
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // two cycles of standby so either gating point of the enable register holds
  a_bus_standby: assert property (standby_mode != 2'h0 &&
    $past(standby_mode) != 2'h0 |-> !bus_clock_en) else $error("bus en in standby");
  a_periph_stop: assert property (standby_mode[1] &&
    $past(standby_mode[1]) |-> !peripheral_clock_one_en &&
    !peripheral_clock_two_en) else $error("periph en in timer or stop");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer timing");
  a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready &&
    !s_axi_wready) else $error("write taken while answer pending");
  a_reset_state: assert property (disable iff (1'b0) !aresetn |=>
    cpu_clock_mode == 2'h0 && !bus_clock_en && !sub_pins_gpio)
    else $error("reset state wrong");
  a_gpio_strap: assert property ($rose(aresetn) |=>
    sub_pins_gpio == $past(sub_osc_config_marker)) else $error("strap not taken");
endmodule // scg_clock_gen_checker

bind scg_clock_gen scg_clock_gen_checker chk_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .sub_osc_config_marker(sub_osc_config_marker), .standby_mode(standby_mode),
  .bus_clock_en(bus_clock_en), .peripheral_clock_one_en(peripheral_clock_one_en),
  .peripheral_clock_two_en(peripheral_clock_two_en),
  .cpu_clock_mode(cpu_clock_mode), .sub_pins_gpio(sub_pins_gpio));

// File: test/scg_clock_gen_test.sv
`timescale 1ns/1ns
`include "scg_defines.vh"
module scg_clock_gen_test;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [7:0] awaddr = 8'h00, araddr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  reg rready = 1'b0, marker = 1'b0, main_on = 1'b0, sub_on = 1'b1;
  reg [1:0] standby = 2'h0;
  wire awready, wready, bvalid, arready, rvalid, main_st, sub_st;
  wire bus_clock_en, peripheral_clock_one_en, peripheral_clock_two_en;
  wire sub_pins_gpio;
  wire [1:0] bresp, rresp, cpu_clock_mode;
  wire [31:0] rdata;
  integer i, cb, c1, c2;
  integer cycles = 0, bad_count = 0, comparisons = 0, seed = 97;
  reg [31:0] d, q, t;
  reg [1:0] rr;

  always #20 aclk = ~aclk;

  scg_clock_gen uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .main_osc_stable(main_st), .sub_osc_stable(sub_st),
    .sub_osc_config_marker(marker), .standby_mode(standby),
    .bus_clock_en(bus_clock_en),
    .peripheral_clock_one_en(peripheral_clock_one_en),
    .peripheral_clock_two_en(peripheral_clock_two_en),
    .cpu_clock_mode(cpu_clock_mode), .sub_pins_gpio(sub_pins_gpio));

  scg_osc_model osc (.aclk(aclk), .main_on(main_on), .sub_on(sub_on),
    .main_osc_stable(main_st), .sub_osc_stable(sub_st));

  task wrap_up;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // pulse counts carry one tick of fractional jitter at each window end
  task near(input integer got, input integer exp);
    chk((got > exp - 3 && got < exp + 3) ? exp : got, exp);
  endtask

  function integer rate(input integer khz, input integer dv, input integer n);
    rate = n * khz / (`SCG_CLK_KHZ * (dv + 1));
  endfunction

  always @(posedge aclk) begin
    cycles = cycles + 1;
    if (cycles == 90000) begin
      bad_count = bad_count + 1;
      wrap_up;
    end
  end

  task wr(input [7:0] a, input [31:0] dt, input [1:0] er);
    reg ta;
    reg tw;
    begin
      awaddr <= a;
      wdata <= dt;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      ta = 1'b0;
      tw = 1'b0;
      while (!(ta && tw)) begin
        @(posedge aclk);
        if (awvalid && awready === 1'b1)
          ta = 1'b1;
        if (wvalid && wready === 1'b1)
          tw = 1'b1;
        awvalid <= !ta;
        wvalid <= !tw;
      end
      // a late bready lets the response stand for a few cycles
      repeat ($random(seed) & 3) @(posedge aclk);
      bready <= 1'b1;
      @(posedge aclk);
      while (bvalid !== 1'b1) @(posedge aclk);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
    end
  endtask

  task rd(input [7:0] a, output [31:0] dt);
    begin
      araddr <= a;
      arvalid <= 1'b1;
      @(posedge aclk);
      while (arready !== 1'b1) @(posedge aclk);
      arvalid <= 1'b0;
      repeat ($random(seed) & 3) @(posedge aclk);
      rready <= 1'b1;
      @(posedge aclk);
      while (rvalid !== 1'b1) @(posedge aclk);
      dt = rdata;
      rr = rresp;
      rready <= 1'b0;
    end
  endtask

  task wait_mon(input [31:0] mask, input [31:0] v);
    begin
      rd(`SCG_OFS_MON, q);
      while ((q & mask) !== v) rd(`SCG_OFS_MON, q);
    end
  endtask

  task measure(input integer n);
    begin
      cb = 0;
      c1 = 0;
      c2 = 0;
      repeat (n) begin
        @(posedge aclk);
        cb = cb + bus_clock_en;
        c1 = c1 + peripheral_clock_one_en;
        c2 = c2 + peripheral_clock_two_en;
      end
    end
  endtask

  task rst(input m);
    begin
      marker <= m;
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      chk({31'h0, sub_pins_gpio}, {31'h0, m});
      chk({30'h0, cpu_clock_mode}, {30'h0, `SCG_SRC_RC});
    end
  endtask

  initial begin
    rst(1'b0);
    rd(`SCG_OFS_SEL, q);
    chk(q, `SCG_SEL_RESET);
    chk({30'h0, rr}, {30'h0, `SCG_RESP_OKAY});
    rd(`SCG_OFS_FREQ, q);
    chk(q, `SCG_FREQ_RESET);
    wr(8'h40, 32'hffffffff, `SCG_RESP_SLVERR);
    rd(8'h40, q);
    chk({30'h0, rr}, {30'h0, `SCG_RESP_SLVERR});
    chk(q, 32'h0);
    wr(`SCG_OFS_MON, 32'hffffffff, `SCG_RESP_OKAY);
    wait_mon(32'h100, 32'h100);
    for (i = 0; i < 4; i = i + 1) begin
      d = (i == 0) ? 32'hfff0f0f0 : $random(seed);
      wr(`SCG_OFS_DIV, d, `SCG_RESP_OKAY);
      rd(`SCG_OFS_DIV, q);
      chk(q, d & `SCG_DIV_WMASK);
      measure(400);
      measure(4000);
      near(cb, rate(`SCG_RC_FAST_KHZ, d[3:0], 4000));
      near(c1, rate(`SCG_RC_FAST_KHZ, d[11:8], 4000));
      near(c2, rate(`SCG_RC_FAST_KHZ, d[19:16], 4000));
    end
    wr(`SCG_OFS_DIV, 32'h0, `SCG_RESP_OKAY);
    for (i = 0; i < 4; i = i + 1) begin
      standby <= i[1:0];
      measure(50);
      measure(300);
      chk({31'h0, cb != 0}, {31'h0, i == 0});
      chk({31'h0, c1 != 0 && c2 != 0}, {31'h0, i < 2});
    end
    standby <= `SCG_MODE_RUN;
    // main oscillator still unstable: the request must wait
    wr(`SCG_OFS_SEL, 32'h00000b01, `SCG_RESP_OKAY);
    measure(600);
    chk({30'h0, cpu_clock_mode}, 32'h0);
    rd(`SCG_OFS_MON, q);
    chk(q & 32'h3, 32'h0);
    chk(q & 32'h600, 32'h0);
    wr(`SCG_OFS_SEL, 32'h00000b00, `SCG_RESP_OKAY);
    main_on <= 1'b1;
    measure(600);
    chk({30'h0, cpu_clock_mode}, 32'h0);
    wr(`SCG_OFS_FREQ, 32'h00000d00, `SCG_RESP_OKAY);
    wr(`SCG_OFS_SEL, 32'h00000b12, `SCG_RESP_OKAY);
    wait_mon(32'h33, 32'h12);
    chk({30'h0, cpu_clock_mode}, {30'h0, `SCG_SRC_PLL});
    measure(2000);
    near(cb, rate(13000, 0, 2000));
    near(c2, rate(1000, 0, 2000));
    wr(`SCG_OFS_SEL, 32'h00000b02, `SCG_RESP_OKAY);
    wr(`SCG_OFS_FREQ, 32'h00000d01, `SCG_RESP_OKAY);
    wait_mon(32'h33, 32'h02);
    measure(300);
    measure(2500);
    chk({30'h0, cpu_clock_mode}, {30'h0, `SCG_SRC_PLL});
    near(cb, rate(13000, 0, 2500));
    near(c2, rate(`SCG_RC_SLOW_KHZ, 0, 2500));
    rd(`SCG_OFS_TMR_MAIN, q);
    measure(300);
    rd(`SCG_OFS_TMR_MAIN, t);
    chk({31'h0, q != t}, 32'h1);
    // sub source on system clock two, at its slow default rate
    wr(`SCG_OFS_SEL, 32'h00000b32, `SCG_RESP_OKAY);
    wait_mon(32'h33, 32'h32);
    measure(12500);
    near(c2, rate(32, 0, 12500));
    rst(1'b1);
    // sub pins released: a sub request must stay pending
    wr(`SCG_OFS_SEL, 32'h00000b03, `SCG_RESP_OKAY);
    measure(1600);
    chk({30'h0, cpu_clock_mode}, {30'h0, `SCG_SRC_RC});
    rd(`SCG_OFS_MON, q);
    chk(q & 32'h800, 32'h0);
    wrap_up;
  end
endmodule // scg_clock_gen_test
